// file: verilog/bmc_pkg.sv
package bmc_pkg;

   // Clock and time base
   localparam int unsigned CLK_HZ            = 100_000_000;
   localparam int unsigned TICK_MS           = 1;
   localparam int unsigned TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;

   // Long timeouts, in their own units, then in ticks
   localparam int unsigned STANDBY_TIMEOUT_H = 48;
   localparam int unsigned OFFLINE_TIMEOUT_H = 48;
   localparam int unsigned UV_HOLD_MIN       = 1;
   localparam int unsigned STANDBY_TICKS     =
      STANDBY_TIMEOUT_H * 3600 * 1000 / TICK_MS;
   localparam int unsigned OFFLINE_TICKS     =
      OFFLINE_TIMEOUT_H * 3600 * 1000 / TICK_MS;
   localparam int unsigned UV_HOLD_TICKS     = UV_HOLD_MIN * 60 * 1000 / TICK_MS;
   localparam int unsigned OC_DELAY_MS       = 100;
   localparam int unsigned OC_RECOVER_MS     = 1000;
   localparam int unsigned OC_DELAY_TICKS    = OC_DELAY_MS / TICK_MS;
   localparam int unsigned OC_RECOVER_TICKS  = OC_RECOVER_MS / TICK_MS;

   // Blink patterns, on and off times in ms
   localparam int unsigned SLOW_ON_MS        = 250;
   localparam int unsigned SLOW_OFF_MS       = 3750;
   localparam int unsigned FAST_ON_MS        = 500;
   localparam int unsigned FAST_OFF_MS       = 500;
   localparam int unsigned MED_ON_MS         = 500;
   localparam int unsigned MED_OFF_MS        = 1500;
   localparam int unsigned BLINK_PERIOD_MS   = SLOW_ON_MS + SLOW_OFF_MS;

   // Register byte offsets
   localparam logic [7:0]  ADDR_MEAS         = 8'h00;
   localparam logic [7:0]  ADDR_EVT          = 8'h04;
   localparam logic [7:0]  ADDR_CFG          = 8'h08;
   localparam logic [7:0]  ADDR_STAT         = 8'h0c;

   // Measurement register fields
   localparam int          M_CHG_PRESENT     = 0;
   localparam int          M_CHG_VOLT_ABOVE  = 1;
   localparam int          M_CHG_CUR_OK      = 2;
   localparam int          M_LOAD_PRESENT    = 3;
   localparam int          M_DSG_CUR_OK      = 4;
   localparam int          M_CELL_OVER       = 5;
   localparam int          M_CELL_OVER_REC   = 6;
   localparam int          M_PACK_OVER       = 7;
   localparam int          M_PACK_OVER_REC   = 8;
   localparam int          M_CELL_UNDER      = 9;
   localparam int          M_PACK_UNDER      = 10;
   localparam int          M_SOC_BELOW_LIM   = 11;
   localparam int          M_CHG_OVER_CUR    = 12;
   localparam int          M_DSG_OVER_CUR    = 13;
   localparam int          M_SHORT_CIRCUIT   = 14;
   localparam int          M_DSG_TEMP        = 15;
   localparam int          M_ALARM           = 16;
   localparam int          M_CHG_LIMITING    = 17;
   localparam int          M_PACK_RECOVERED  = 18;
   localparam int          MEAS_BITS         = 19;

   // Event register fields, write one to pulse
   localparam int          E_KEY_PRESS       = 0;
   localparam int          E_LONG_KEY        = 1;
   localparam int          E_EXT_OFF         = 2;
   localparam int          E_EXT_ON          = 3;
   localparam int          E_WAKE_PACK       = 4;
   localparam int          E_RESET_BUTTON    = 5;
   localparam int          EVT_BITS          = 6;

   // Configuration fields and reset values
   localparam int          C_BAND_LSB        = 0;
   localparam int          C_LOCK_LSB        = 4;
   localparam logic [1:0]  CFG_BAND_RST      = 2'h0;
   localparam logic [3:0]  CFG_LOCK_RST      = 4'h5;

   typedef enum logic [1:0] {
      MODE_OFF  = 2'b00,
      MODE_STBY = 2'b01,
      MODE_CHG  = 2'b11,
      MODE_DSG  = 2'b10
   } bmc_mode_t;

endpackage

// file: verilog/bmc_battery_ctrl.sv
// Contract
// [RULE1] Charge needs charger, voltage margin, current
// [RULE2] Discharge needs load and discharge current
// [RULE3] Otherwise standby
// [RULE4] Shutdown on timeout, undervoltage, key, switch
// [RULE5] Wake on charger, pack input, key, switch
// [RULE6] Six lamps: run, alarm, four capacity
// [RULE7] Capacity lamps solid, charging band blinks
// [RULE8] Three blink patterns with fixed times
// [RULE9] Standby blinks run lamp, both directions allowed
// [RULE10] Charging: run solid, band and alarm fast
// [RULE11] Discharge protection: stop, alarm solid, offline sleep
// [RULE12] Reset button boots healthy device to standby
// [RULE13] Cell overvoltage blocks charging
// [RULE14] Cell overvoltage clears on recovery or discharge
// [RULE15] Pack overvoltage blocks charging, clears likewise
// [RULE16] Undervoltage blocks discharge, shutdown after minute
// [RULE17] Undervoltage cleared by charge or reset recheck
// [RULE18] After undervoltage wake, no discharge one minute
// [RULE19] Charge overcurrent only without limiting, after delay
// [RULE20] Charge overcurrent recovers after delay or discharge
// [RULE21] Discharge overcurrent after delay, recovers or charge
// [RULE22] Transient count locks until reboot or charge
// [RULE23] Short-circuit lock released only by charger
module bmc_battery_ctrl #(
   parameter int unsigned TICK_CYC    = bmc_pkg::TICK_CYCLES,
   parameter int unsigned STBY_TICKS  = bmc_pkg::STANDBY_TICKS,
   parameter int unsigned OFF_TICKS   = bmc_pkg::OFFLINE_TICKS,
   parameter int unsigned HOLD_TICKS  = bmc_pkg::UV_HOLD_TICKS,
   parameter int unsigned OCD_TICKS   = bmc_pkg::OC_DELAY_TICKS,
   parameter int unsigned OCR_TICKS   = bmc_pkg::OC_RECOVER_TICKS
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             runLampOut,
   output logic             alertLampOut,
   output logic             capacityLampLowest,
   output logic             capacityLampSecond,
   output logic             capacityLampThird,
   output logic             capacityLampHighest
);

   function automatic logic [3:0] bandMask(input logic [1:0] band);
      // Band n lights lamps zero up to n
      bandMask = 4'hf >> (2'h3 - band);
   endfunction

   function automatic logic [31:0] countStep(input logic [31:0] cnt,
                                             input logic        run,
                                             input logic        tick);
      if (!run)
         countStep = 32'h0;
      else if (tick && cnt != 32'hffffffff)
         countStep = cnt + 32'h1;
      else
         countStep = cnt;
   endfunction

   // ---------------- AHB-Lite slave ----------------
   logic [31:0] meas_r, meas_nxt;
   logic [5:0]  evt_r, evt_nxt;
   logic [1:0]  band_r, band_nxt;
   logic [3:0]  lockLim_r, lockLim_nxt;
   logic        wrPend_r, wrPend_nxt;
   logic [7:0]  wrAddr_r, wrAddr_nxt;
   logic [31:0] rdata_nxt;
   logic [31:0] status;
   logic        accept;

   assign accept = hsel && hready && htrans[1] && hsize == 3'h2;

   always_comb begin
      meas_nxt    = meas_r;
      evt_nxt     = '0;
      band_nxt    = band_r;
      lockLim_nxt = lockLim_r;
      wrPend_nxt  = accept && hwrite;
      wrAddr_nxt  = accept ? haddr[7:0] : wrAddr_r;
      rdata_nxt   = hrdata;
      if (wrPend_r) begin
         unique case (wrAddr_r)
            bmc_pkg::ADDR_MEAS: meas_nxt = {13'h0, hwdata[18:0]};
            bmc_pkg::ADDR_EVT:  evt_nxt  = hwdata[5:0];
            bmc_pkg::ADDR_CFG: begin
               band_nxt    = hwdata[bmc_pkg::C_BAND_LSB +: 2];
               lockLim_nxt = hwdata[bmc_pkg::C_LOCK_LSB +: 4];
            end
            default: ;
         endcase
      end
      if (accept && !hwrite) begin
         unique case (haddr[7:0])
            bmc_pkg::ADDR_MEAS: rdata_nxt = meas_r;
            bmc_pkg::ADDR_CFG:  rdata_nxt = {24'h0, lockLim_r, 2'h0, band_r};
            bmc_pkg::ADDR_STAT: rdata_nxt = status;
            default:            rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meas_r    <= 32'h0;
         evt_r     <= 6'h0;
         band_r    <= bmc_pkg::CFG_BAND_RST;
         lockLim_r <= bmc_pkg::CFG_LOCK_RST;
         wrPend_r  <= 1'b0;
         wrAddr_r  <= 8'h0;
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         meas_r    <= meas_nxt;
         evt_r     <= evt_nxt;
         band_r    <= band_nxt;
         lockLim_r <= lockLim_nxt;
         wrPend_r  <= wrPend_nxt;
         wrAddr_r  <= wrAddr_nxt;
         hrdata    <= rdata_nxt;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ---------------- Mode and protection ----------------
   logic chgPresent, chgCond, dsgCond, dsgProt, wakeEvt, tick;
   logic [31:0] tickCnt_r, tickCnt_nxt;
   bmc_pkg::bmc_mode_t mode_r, mode_nxt;
   logic ovChg_r, ovChg_nxt, udv_r, udv_nxt, uvOff_r, uvOff_nxt;
   logic chgOc_r, chgOc_nxt, dsgOc_r, dsgOc_nxt, scLock_r, scLock_nxt;
   logic lock_r, lock_nxt;
   logic [3:0]  trans_r, trans_nxt;
   logic [31:0] stbyCnt_r, offCnt_r, udvCnt_r, wakeCnt_r;
   logic [31:0] stbyCnt_nxt, offCnt_nxt, udvCnt_nxt, wakeCnt_nxt;
   logic [31:0] chgOcCnt_r, dsgOcCnt_r, chgOcCnt_nxt, dsgOcCnt_nxt;

   assign tick       = tickCnt_r == 32'(TICK_CYC - 1);
   assign chgPresent = meas_r[bmc_pkg::M_CHG_PRESENT];
   // [RULE11] discharge stopping protections
   assign dsgProt    = meas_r[bmc_pkg::M_DSG_TEMP] || dsgOc_r || scLock_r;
   // [RULE1] charge entry condition
   assign chgCond    = chgPresent && meas_r[bmc_pkg::M_CHG_VOLT_ABOVE]
                       && meas_r[bmc_pkg::M_CHG_CUR_OK] && !ovChg_r
                       && !chgOc_r;
   // [RULE2] discharge entry condition
   assign dsgCond    = meas_r[bmc_pkg::M_LOAD_PRESENT]
                       && meas_r[bmc_pkg::M_DSG_CUR_OK] && !udv_r
                       && !dsgProt && wakeCnt_r == 32'h0;
   // [RULE5] wake events
   assign wakeEvt    = chgPresent || evt_r[bmc_pkg::E_WAKE_PACK]
                       || evt_r[bmc_pkg::E_KEY_PRESS]
                       || evt_r[bmc_pkg::E_EXT_ON]
                       || evt_r[bmc_pkg::E_RESET_BUTTON];
   assign status = {20'h0, trans_r, lock_r, scLock_r, dsgOc_r, chgOc_r,
                    udv_r, ovChg_r, mode_r};

   always_comb begin
      tickCnt_nxt = tick ? 32'h0 : tickCnt_r + 32'h1;
      mode_nxt    = mode_r;
      ovChg_nxt   = ovChg_r;
      udv_nxt     = udv_r;
      uvOff_nxt   = uvOff_r;
      chgOc_nxt   = chgOc_r;
      dsgOc_nxt   = dsgOc_r;
      scLock_nxt  = scLock_r;
      lock_nxt    = lock_r;
      trans_nxt   = trans_r;
      wakeCnt_nxt = (wakeCnt_r != 32'h0 && tick) ? wakeCnt_r - 32'h1
                                                  : wakeCnt_r;
      // [RULE14] cell and [RULE15] pack recovery together with SOC below limit, or discharge
      if ((meas_r[bmc_pkg::M_CELL_OVER_REC] && meas_r[bmc_pkg::M_PACK_OVER_REC]
           && meas_r[bmc_pkg::M_SOC_BELOW_LIM]) || mode_r == bmc_pkg::MODE_DSG)
         ovChg_nxt = 1'b0;
      // [RULE13] overvoltage sets, winning over the clear
      if (meas_r[bmc_pkg::M_CELL_OVER] || meas_r[bmc_pkg::M_PACK_OVER])
         ovChg_nxt = 1'b1;
      // [RULE17] charge or reset-button recheck releases undervoltage
      if (mode_r == bmc_pkg::MODE_CHG || (evt_r[bmc_pkg::E_RESET_BUTTON]
          && meas_r[bmc_pkg::M_PACK_RECOVERED]))
         udv_nxt = 1'b0;
      // [RULE16] undervoltage sets
      if (meas_r[bmc_pkg::M_CELL_UNDER] || meas_r[bmc_pkg::M_PACK_UNDER])
         udv_nxt = 1'b1;
      // [RULE20] charge overcurrent recheck after delay, or discharge
      if ((chgOc_r && chgOcCnt_r >= 32'(OCR_TICKS)
           && !meas_r[bmc_pkg::M_CHG_OVER_CUR]) || mode_r == bmc_pkg::MODE_DSG)
         chgOc_nxt = 1'b0;
      // [RULE19] only without charge current limiting
      if (!chgOc_r && chgOcCnt_r >= 32'(OCD_TICKS))
         chgOc_nxt = 1'b1;
      // [RULE21] recovery after delay and recheck, or charging
      if ((dsgOc_r && !lock_r && dsgOcCnt_r >= 32'(OCR_TICKS)
           && !meas_r[bmc_pkg::M_DSG_OVER_CUR]) || mode_r == bmc_pkg::MODE_CHG)
         dsgOc_nxt = 1'b0;
      // [RULE22] transient count and lock, released by charge or reboot
      if (mode_r == bmc_pkg::MODE_CHG || mode_r == bmc_pkg::MODE_OFF) begin
         lock_nxt  = 1'b0;
         trans_nxt = 4'h0;
      end
      if (!dsgOc_r && dsgOcCnt_r >= 32'(OCD_TICKS)) begin
         dsgOc_nxt = 1'b1;
         if (trans_r != 4'hf)
            trans_nxt = trans_r + 4'h1;
         if (trans_r + 4'h1 >= lockLim_r)
            lock_nxt = 1'b1;
      end
      // [RULE23] only a charger releases the short-circuit lock
      if (chgPresent)
         scLock_nxt = 1'b0;
      if (meas_r[bmc_pkg::M_SHORT_CIRCUIT])
         scLock_nxt = 1'b1;
      unique case (mode_r)
         bmc_pkg::MODE_OFF: begin
            // [RULE12] reset button boots unless undervoltage is set without pack recovery
            if (wakeEvt && !(evt_r[bmc_pkg::E_RESET_BUTTON] && (udv_r
                && !meas_r[bmc_pkg::M_PACK_RECOVERED]))) begin
               mode_nxt  = bmc_pkg::MODE_STBY;
               uvOff_nxt = 1'b0;
               // [RULE18] hold output, forbid discharge one minute
               if (uvOff_r && (chgPresent || evt_r[bmc_pkg::E_KEY_PRESS]
                   || evt_r[bmc_pkg::E_RESET_BUTTON]))
                  wakeCnt_nxt = 32'(HOLD_TICKS);
            end
         end
         default: begin
            // [RULE3] standby unless charge or discharge qualifies
            if (chgCond)
               mode_nxt = bmc_pkg::MODE_CHG;
            else if (dsgCond)
               mode_nxt = bmc_pkg::MODE_DSG;
            else
               mode_nxt = bmc_pkg::MODE_STBY;
            // [RULE4] shutdown causes; all four override charge and discharge
            if (stbyCnt_r >= 32'(STBY_TICKS) || evt_r[bmc_pkg::E_LONG_KEY]
                || evt_r[bmc_pkg::E_EXT_OFF]
                || offCnt_r >= 32'(OFF_TICKS))
               mode_nxt = bmc_pkg::MODE_OFF;
            // [RULE16] shutdown after one minute of communication
            if (udvCnt_r >= 32'(HOLD_TICKS) && mode_nxt != bmc_pkg::MODE_CHG)
            begin
               mode_nxt  = bmc_pkg::MODE_OFF;
               uvOff_nxt = 1'b1;
            end
         end
      endcase
      stbyCnt_nxt  = countStep(stbyCnt_r, mode_r == bmc_pkg::MODE_STBY, tick);
      // [RULE11] forced sleep while mains stays absent
      offCnt_nxt   = countStep(offCnt_r, dsgProt && !chgPresent
                               && mode_r != bmc_pkg::MODE_OFF, tick);
      udvCnt_nxt   = countStep(udvCnt_r, udv_r
                               && mode_r != bmc_pkg::MODE_OFF, tick);
      chgOcCnt_nxt = countStep(chgOcCnt_r, chgOc_r
                               || (meas_r[bmc_pkg::M_CHG_OVER_CUR]
                               && !meas_r[bmc_pkg::M_CHG_LIMITING]), tick);
      dsgOcCnt_nxt = countStep(dsgOcCnt_r, dsgOc_r
                               || meas_r[bmc_pkg::M_DSG_OVER_CUR], tick);
      if (chgOc_nxt != chgOc_r)
         chgOcCnt_nxt = 32'h0;
      if (dsgOc_nxt != dsgOc_r)
         dsgOcCnt_nxt = 32'h0;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tickCnt_r  <= 32'h0;
         mode_r     <= bmc_pkg::MODE_OFF;
         ovChg_r    <= 1'b0;
         udv_r      <= 1'b0;
         uvOff_r    <= 1'b0;
         chgOc_r    <= 1'b0;
         dsgOc_r    <= 1'b0;
         scLock_r   <= 1'b0;
         lock_r     <= 1'b0;
         trans_r    <= 4'h0;
         stbyCnt_r  <= 32'h0;
         offCnt_r   <= 32'h0;
         udvCnt_r   <= 32'h0;
         wakeCnt_r  <= 32'h0;
         chgOcCnt_r <= 32'h0;
         dsgOcCnt_r <= 32'h0;
      end else begin
         tickCnt_r  <= tickCnt_nxt;
         mode_r     <= mode_nxt;
         ovChg_r    <= ovChg_nxt;
         udv_r      <= udv_nxt;
         uvOff_r    <= uvOff_nxt;
         chgOc_r    <= chgOc_nxt;
         dsgOc_r    <= dsgOc_nxt;
         scLock_r   <= scLock_nxt;
         lock_r     <= lock_nxt;
         trans_r    <= trans_nxt;
         stbyCnt_r  <= stbyCnt_nxt;
         offCnt_r   <= offCnt_nxt;
         udvCnt_r   <= udvCnt_nxt;
         wakeCnt_r  <= wakeCnt_nxt;
         chgOcCnt_r <= chgOcCnt_nxt;
         dsgOcCnt_r <= dsgOcCnt_nxt;
      end
   end

   // ---------------- Blink and lamps ----------------
   logic [11:0] phase_r, phase_nxt;
   logic        slowBlinkPattern, fastBlinkPattern, medBlinkPattern;
   logic        alarm;
   logic [5:0]  lamps_nxt;
   logic [3:0]  capMask;

   // [RULE8] all periods divide the slow period, one phase counter
   assign slowBlinkPattern = phase_r < 12'(bmc_pkg::SLOW_ON_MS);
   assign fastBlinkPattern = (phase_r % 12'(bmc_pkg::FAST_ON_MS
                       + bmc_pkg::FAST_OFF_MS)) < 12'(bmc_pkg::FAST_ON_MS);
   assign medBlinkPattern  = (phase_r % 12'(bmc_pkg::MED_ON_MS
                       + bmc_pkg::MED_OFF_MS)) < 12'(bmc_pkg::MED_ON_MS);
   assign alarm     = meas_r[bmc_pkg::M_ALARM];
   assign capMask   = bandMask(band_r);

   always_comb begin
      phase_nxt = phase_r;
      if (tick)
         phase_nxt = (phase_r == 12'(bmc_pkg::BLINK_PERIOD_MS - 1)) ? 12'h0
                     : phase_r + 12'h1;
      // Order: run, alert, capacity lamps highest down to lowest
      lamps_nxt = 6'h0;
      unique case (mode_r)
         bmc_pkg::MODE_OFF: lamps_nxt = 6'h0;
         bmc_pkg::MODE_CHG: begin
            // [RULE10] run solid, alarm and top band fast
            // [RULE7] lower bands solid, current band blinks
            lamps_nxt = {1'b1, alarm && fastBlinkPattern,
                         capMask & ~(fastBlinkPattern ? 4'h0
                         : (capMask ^ (capMask >> 1)))};
         end
         bmc_pkg::MODE_DSG: begin
            // [RULE7] solid up to the band
            lamps_nxt = {medBlinkPattern, alarm && medBlinkPattern, capMask};
         end
         default: begin
            // [RULE9] standby blinks run; [RULE11] alarm solid
            if (udv_r)
               lamps_nxt = 6'h0;
            else if (dsgProt)
               lamps_nxt = 6'b010000;
            else if (chgOc_r)
               lamps_nxt = {slowBlinkPattern, slowBlinkPattern, 4'h0};
            else
               lamps_nxt = {slowBlinkPattern, 5'h0};
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_r <= 12'h0;
         {runLampOut, alertLampOut, capacityLampHighest, capacityLampThird,
          capacityLampSecond, capacityLampLowest} <= 6'h0;
      end else begin
         phase_r <= phase_nxt;
         // [RULE6] six lamp outputs
         {runLampOut, alertLampOut, capacityLampHighest, capacityLampThird,
          capacityLampSecond, capacityLampLowest} <= lamps_nxt;
      end
   end

   // ---------------- Assertions ----------------
   a_chg_entry: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
      $rose(mode_r == bmc_pkg::MODE_CHG) |-> $past(chgPresent)
         && !$past(ovChg_r))
      else $error("charge entered without charger");
   a_udv_blocks: assert property (@(posedge clk) disable iff (!rst_n) // [RULE16]
      udv_r |=> mode_r != bmc_pkg::MODE_DSG)
      else $error("discharge during undervoltage");
   a_off_dark: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
      mode_r == bmc_pkg::MODE_OFF ##1 mode_r == bmc_pkg::MODE_OFF |->
         !runLampOut && !alertLampOut && !capacityLampLowest)
      else $error("lamp lit in shutdown");
   a_ovchg_block: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
      ovChg_r |=> mode_r != bmc_pkg::MODE_CHG)
      else $error("charge during overvoltage");
   a_sc_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE23]
      scLock_r && !chgPresent |=> scLock_r)
      else $error("short lock released without charger");
   a_wake_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE18]
      wakeCnt_r != 32'h0 |=> mode_r != bmc_pkg::MODE_DSG)
      else $error("discharge inside wake hold");
   a_blink_edge: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
      phase_r == 12'h0fa |-> !slowBlinkPattern && fastBlinkPattern
         && medBlinkPattern)
      else $error("blink phase wrong at 250 ms");
   a_lock_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE22]
      lock_r && dsgOc_r && mode_r == bmc_pkg::MODE_STBY && !chgCond
         && !$rose(dsgOc_r) |=> dsgOc_r)
      else $error("locked overcurrent recovered");

endmodule

// file: bench/bmc_lamp_watch.sv
module bmc_lamp_watch (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        lamp,
   output logic [31:0]      onLen,
   output logic [31:0]      offLen
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] cnt_r;
   logic        last_r;
   // Lamp time capture
   // A change closes the run; only whole runs are reported
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r  <= 32'h0;
         last_r <= 1'b0;
         onLen  <= 32'h0;
         offLen <= 32'h0;
      end else if (lamp !== last_r) begin
         if (last_r) onLen <= cnt_r;
         else offLen <= cnt_r;
         cnt_r  <= 32'h1;
         last_r <= lamp;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end
endmodule

// file: bench/battery_mode_led_controller_tb.sv
module battery_mode_led_controller_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TC = 4;
   localparam int SB = 9000;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] m;} bmc_row_t;
   logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hresp, hreadyout;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q, rOn, rOff, cOn, cOff;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 0;
   logic        runL, alL, c1, c2, c3, c4;
   int          num_errors = 0, n_checks = 0;
   bmc_row_t    rows [11] = '{
      '{8'h04, 32'h01, 2'h1}, '{8'h00, 32'h07, 2'h3}, '{8'h00, 32'h03, 2'h1},
      '{8'h00, 32'h18, 2'h2}, '{8'h00, 32'h08, 2'h1}, '{8'h00, 32'h06, 2'h1},
      '{8'h00, 32'h00, 2'h1}, '{8'h04, 32'h02, 2'h0}, '{8'h04, 32'h08, 2'h1},
      '{8'h04, 32'h04, 2'h0}, '{8'h04, 32'h10, 2'h1}};
   always #5 clk = ~clk;
   bmc_battery_ctrl #(.TICK_CYC(TC), .STBY_TICKS(SB), .OFF_TICKS(50),
      .HOLD_TICKS(10), .OCD_TICKS(3), .OCR_TICKS(5)) dut (
      .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .runLampOut(runL), .alertLampOut(alL), .capacityLampLowest(c1),
      .capacityLampSecond(c2), .capacityLampThird(c3),
      .capacityLampHighest(c4));
   bmc_lamp_watch wr (.clk(clk), .rst_n(rst_n), .lamp(runL), .onLen(rOn),
      .offLen(rOff));
   bmc_lamp_watch wc (.clk(clk), .rst_n(rst_n), .lamp(c2), .onLen(cOn),
      .offLen(cOff));
   task automatic end_sim;
      if (num_errors == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_rdy;
      int i;
      i = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         i++;
         if (i > 100) begin
            num_errors++;
            end_sim();
         end
         @(posedge clk);
      end
   endtask
   // Address phase held until hready, then data phase until hready
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      wait_rdy();
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic mode(input logic [1:0] m);
      repeat (8) @(posedge clk);
      ahb(1'b0, bmc_pkg::ADDR_STAT, 32'h0);
      chk({30'h0, q[1:0]}, {30'h0, m});
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      chk({26'h0, runL, alL, c1, c2, c3, c4}, 32'h0);
      ahb(1'b0, bmc_pkg::ADDR_CFG, 32'h0);
      chk(q, 32'h50);
      ahb(1'b0, 8'h10, 32'h0);
      chk(q, 32'h0);
      foreach (rows[i]) begin
         ahb(1'b1, rows[i].a, rows[i].d);
         mode(rows[i].m);
      end
      repeat (33000) @(posedge clk);
      chk(rOn, bmc_pkg::SLOW_ON_MS * TC);
      chk(rOff, bmc_pkg::SLOW_OFF_MS * TC);
      mode(2'h1);
      repeat (SB * TC - 33000 + 100) @(posedge clk);
      mode(2'h0);
      ahb(1'b1, bmc_pkg::ADDR_EVT, 32'h01);
      ahb(1'b1, bmc_pkg::ADDR_CFG, 32'h51);
      ahb(1'b1, bmc_pkg::ADDR_MEAS, 32'h07);
      repeat (9000) @(posedge clk);
      chk({28'h0, runL, c1, c3, c4}, 32'hc);
      chk(cOn, bmc_pkg::FAST_ON_MS * TC);
      chk(cOff, bmc_pkg::FAST_OFF_MS * TC);
      ahb(1'b1, bmc_pkg::ADDR_MEAS, 32'h27);
      mode(2'h1);
      chk({29'h0, q[2:0]}, 32'h5);
      // One flag covers cell and pack, so both recovery bits are needed
      ahb(1'b1, bmc_pkg::ADDR_MEAS, 32'h947);
      mode(2'h3);
      chk({29'h0, q[2:0]}, 32'h3);
      ahb(1'b1, bmc_pkg::ADDR_MEAS, 32'h18);
      mode(2'h2);
      ahb(1'b1, bmc_pkg::ADDR_MEAS, 32'h2018);
      repeat (5 * TC) @(posedge clk);
      mode(2'h1);
      chk({30'h0, q[5], alL}, 32'h3);
      // Mid-run reset must return every flag and lamp to idle
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      chk({26'h0, runL, alL, c1, c2, c3, c4}, 32'h0);
      ahb(1'b0, bmc_pkg::ADDR_STAT, 32'h0);
      chk(q, 32'h0);
      ahb(1'b1, bmc_pkg::ADDR_EVT, 32'h01);
      ahb(1'b1, bmc_pkg::ADDR_MEAS, 32'h218);
      mode(2'h1);
      chk({28'h0, q[3:0]}, 32'h9);
      repeat (10 * TC) @(posedge clk);
      mode(2'h0);
      ahb(1'b1, bmc_pkg::ADDR_MEAS, 32'h40018);
      ahb(1'b1, bmc_pkg::ADDR_EVT, 32'h20);
      mode(2'h1);
      chk({28'h0, q[3:0]}, 32'h1);
      repeat (10 * TC) @(posedge clk);
      mode(2'h2);
      end_sim();
   end
endmodule
